//--- cpu_model.sv
`timescale 1ns/1ns
module cpu_model import timer_irq_pkg::*; (input wire logic sys_clk, output reg_req_t reg_req,
	input wire logic [7:0] reg_rdata);
	initial reg_req = '0;
	// never reads the clear register to modify it
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk) reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk) reg_req <= '0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge sys_clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk) reg_req <= '0;
		@(negedge sys_clk) q = reg_rdata;
	endtask : rd
endmodule : cpu_model

//--- timer_irq_consts.svh
`ifndef TIMER_IRQ_CONSTS_SVH
`define TIMER_IRQ_CONSTS_SVH

// register offsets on the plain port
`define TIMER_IRQ_CONTROL_OFFSET 4'h0
`define TIMER_IRQ_CLEAR_OFFSET 4'h1

// control register layout: enables in 7..4, pending flags in 3..0
`define PENDING_LSB 0
`define ENABLE_LSB 4
`define CONTROL_RESET 8'h00

// clear register: reads as all ones, only bits 3..0 act
`define CLEAR_READ_VALUE 8'hFF
`define CLEAR_ACTIVE_MASK 8'h0F

// value read back from an unmapped address
`define UNMAPPED_READ_VALUE 8'h00

`endif

//--- timer_irq_pending_clear.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "timer_irq_consts.svh"
module timer_irq_pending_clear
	import timer_irq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire src_bits_t hw_event,
	output src_bits_t pending,
	output logic timer_irq
);

	// decode of one register address; read and write paths share it
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	// pick the four-bit field that starts at a given bit of a byte
	function automatic src_bits_t field_of(input logic [7:0] b, input int lsb);
		field_of = src_bits_t'(b[lsb +: 4]);
	endfunction : field_of

	// reset and read-back values; reset splits into the two control halves
	localparam logic [7:0] CTL_RESET = `CONTROL_RESET;
	localparam logic [7:0] CLR_READ = `CLEAR_READ_VALUE;
	localparam logic [7:0] UNMAPPED_READ = `UNMAPPED_READ_VALUE;
	localparam logic [7:0] CLR_MASK = `CLEAR_ACTIVE_MASK;
	localparam src_bits_t PEND_RESET = src_bits_t'(CTL_RESET[`PENDING_LSB +: 4]);
	localparam src_bits_t EN_RESET = src_bits_t'(CTL_RESET[`ENABLE_LSB +: 4]);

	// address decode and register strobes
	logic ctl_sel;
	logic clr_sel;
	logic ctl_wr;
	logic clr_wr;
	logic ctl_rd;
	logic clr_rd;
	src_bits_t sw_set;
	src_bits_t sw_clear;
	src_bits_t wr_enable;

	// per-source set and clear requests
	logic set_req_a;
	logic set_req_b;
	logic set_req_c;
	logic set_req_d;
	logic clr_req_a;
	logic clr_req_b;
	logic clr_req_c;
	logic clr_req_d;

	// per-source flag and enable state
	logic src_a_pending_ff;
	logic src_b_pending_ff;
	logic src_c_pending_ff;
	logic src_d_pending_ff;
	logic nxt_src_a_pending;
	logic nxt_src_b_pending;
	logic nxt_src_c_pending;
	logic nxt_src_d_pending;
	logic src_a_enable_ff;
	logic src_b_enable_ff;
	logic src_c_enable_ff;
	logic src_d_enable_ff;
	logic nxt_src_a_enable;
	logic nxt_src_b_enable;
	logic nxt_src_c_enable;
	logic nxt_src_d_enable;

	// per-source request terms, packed views and the read path
	logic src_a_irq;
	logic src_b_irq;
	logic src_c_irq;
	logic src_d_irq;
	src_bits_t pending_bits;
	src_bits_t enable_bits;
	logic [7:0] nxt_rdata;
	logic [7:0] rdata_ff;

	// address decode; each address selects at most one register
	always_comb begin
		ctl_sel = 1'b0;
		clr_sel = 1'b0;
		if (hit(reg_req.addr, `TIMER_IRQ_CONTROL_OFFSET)) begin
			ctl_sel = 1'b1;
		end else if (hit(reg_req.addr, `TIMER_IRQ_CLEAR_OFFSET)) begin
			clr_sel = 1'b1;
		end
	end

	// strobes qualified by the decode
	assign ctl_wr = reg_req.wr && ctl_sel;
	assign clr_wr = reg_req.wr && clr_sel;
	assign ctl_rd = reg_req.rd && ctl_sel;
	assign clr_rd = reg_req.rd && clr_sel;

	// ones written to the pending field set flags; zeros there are ignored
	assign sw_set = ctl_wr ? field_of(reg_req.wdata, `PENDING_LSB) : '0;
	// clear bits 3..0 act on d..a; reserved bits are masked off
	assign sw_clear = clr_wr ? field_of(reg_req.wdata & CLR_MASK, 0) : '0;
	// enable field of a control write
	assign wr_enable = field_of(reg_req.wdata, `ENABLE_LSB);

	// a flag is set by its hardware event or by a software one
	assign set_req_a = sw_set.src_a | hw_event.src_a;
	assign set_req_b = sw_set.src_b | hw_event.src_b;
	assign set_req_c = sw_set.src_c | hw_event.src_c;
	assign set_req_d = sw_set.src_d | hw_event.src_d;

	// a flag is dropped only through the clear register
	assign clr_req_a = sw_clear.src_a;
	assign clr_req_b = sw_clear.src_b;
	assign clr_req_c = sw_clear.src_c;
	assign clr_req_d = sw_clear.src_d;

	// source a next value: clear first, so a set in the same cycle wins
	always_comb begin
		nxt_src_a_pending = src_a_pending_ff;
		if (clr_req_a) begin
			nxt_src_a_pending = 1'b0;
		end
		if (set_req_a) begin
			nxt_src_a_pending = 1'b1;
		end
	end

	// source b next value
	always_comb begin
		nxt_src_b_pending = src_b_pending_ff;
		if (clr_req_b) begin
			nxt_src_b_pending = 1'b0;
		end
		if (set_req_b) begin
			nxt_src_b_pending = 1'b1;
		end
	end

	// source c next value
	always_comb begin
		nxt_src_c_pending = src_c_pending_ff;
		if (clr_req_c) begin
			nxt_src_c_pending = 1'b0;
		end
		if (set_req_c) begin
			nxt_src_c_pending = 1'b1;
		end
	end

	// source d next value
	always_comb begin
		nxt_src_d_pending = src_d_pending_ff;
		if (clr_req_d) begin
			nxt_src_d_pending = 1'b0;
		end
		if (set_req_d) begin
			nxt_src_d_pending = 1'b1;
		end
	end

	// source a pending flag
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_a_pending_ff <= PEND_RESET.src_a;
		end else begin
			src_a_pending_ff <= nxt_src_a_pending;
		end
	end

	// source b pending flag
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_b_pending_ff <= PEND_RESET.src_b;
		end else begin
			src_b_pending_ff <= nxt_src_b_pending;
		end
	end

	// source c pending flag
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_c_pending_ff <= PEND_RESET.src_c;
		end else begin
			src_c_pending_ff <= nxt_src_c_pending;
		end
	end

	// source d pending flag
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_d_pending_ff <= PEND_RESET.src_d;
		end else begin
			src_d_pending_ff <= nxt_src_d_pending;
		end
	end

	// source a enable: plain storage written with the control byte
	always_comb begin
		nxt_src_a_enable = src_a_enable_ff;
		if (ctl_wr) begin
			nxt_src_a_enable = wr_enable.src_a;
		end
	end

	// source b enable
	always_comb begin
		nxt_src_b_enable = src_b_enable_ff;
		if (ctl_wr) begin
			nxt_src_b_enable = wr_enable.src_b;
		end
	end

	// source c enable
	always_comb begin
		nxt_src_c_enable = src_c_enable_ff;
		if (ctl_wr) begin
			nxt_src_c_enable = wr_enable.src_c;
		end
	end

	// source d enable
	always_comb begin
		nxt_src_d_enable = src_d_enable_ff;
		if (ctl_wr) begin
			nxt_src_d_enable = wr_enable.src_d;
		end
	end

	// source a enable register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_a_enable_ff <= EN_RESET.src_a;
		end else begin
			src_a_enable_ff <= nxt_src_a_enable;
		end
	end

	// source b enable register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_b_enable_ff <= EN_RESET.src_b;
		end else begin
			src_b_enable_ff <= nxt_src_b_enable;
		end
	end

	// source c enable register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_c_enable_ff <= EN_RESET.src_c;
		end else begin
			src_c_enable_ff <= nxt_src_c_enable;
		end
	end

	// source d enable register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			src_d_enable_ff <= EN_RESET.src_d;
		end else begin
			src_d_enable_ff <= nxt_src_d_enable;
		end
	end

	// read value for the addressed register; clear register holds nothing
	always_comb begin
		nxt_rdata = 8'h00; // idle between reads
		if (ctl_rd) begin
			nxt_rdata = {enable_bits, pending_bits};
		end else if (clr_rd) begin
			nxt_rdata = CLR_READ;
		end else if (reg_req.rd) begin
			nxt_rdata = UNMAPPED_READ;
		end
	end

	// read data register: stands for one cycle after the strobe only
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// packed views of the per-source state
	assign pending_bits = {src_d_pending_ff, src_c_pending_ff, src_b_pending_ff, src_a_pending_ff};
	assign enable_bits = {src_d_enable_ff, src_c_enable_ff, src_b_enable_ff, src_a_enable_ff};

	// per-source request terms; d is gated by its own enable like the rest
	assign src_a_irq = src_a_pending_ff & src_a_enable_ff;
	assign src_b_irq = src_b_pending_ff & src_b_enable_ff;
	assign src_c_irq = src_c_pending_ff & src_c_enable_ff;
	assign src_d_irq = src_d_pending_ff & src_d_enable_ff;

	// one level request line
	assign timer_irq = src_a_irq | src_b_irq | src_c_irq | src_d_irq;

	// outputs
	assign pending = pending_bits;
	assign reg_rdata = rdata_ff;

endmodule : timer_irq_pending_clear

//--- timer_irq_pending_clear_tb_top.sv
`timescale 1ns/1ns
module timer_irq_pending_clear_tb_top import timer_irq_pkg::*; ;
	logic sys_clk = 0, reset = 1, timer_irq;
	logic [7:0] reg_rdata, q;
	reg_req_t reg_req;
	src_bits_t hw_event = '0, pending;
	int failures = 0, checked = 0;
	initial forever #5 sys_clk = ~sys_clk;
	timer_irq_pending_clear timer_irq_pending_clear_i (.*);
	cpu_model cpu_model_i (.*);
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("ERROR %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	task results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	// watchdog
	initial begin
		#20000 failures++;
		results();
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 0;
		cpu_model_i.rd(4'h0, q); chk(q, 8'h00);
		cpu_model_i.wr(4'h0, 8'h87); cpu_model_i.rd(4'h0, q); chk(q, 8'h87);
		chk({7'h0, timer_irq}, 8'h00);
		@(posedge sys_clk) hw_event <= 4'h8;
		@(posedge sys_clk) hw_event <= 4'h0;
		@(negedge sys_clk) chk({7'h0, timer_irq}, 8'h01);
		cpu_model_i.wr(4'h0, 8'h00); cpu_model_i.rd(4'h0, q); chk(q, 8'h0F);
		chk({7'h0, timer_irq}, 8'h00);
		cpu_model_i.wr(4'h1, 8'hF5); cpu_model_i.rd(4'h0, q); chk(q, 8'h0A);
		cpu_model_i.rd(4'h1, q); chk(q, 8'hFF);
		fork
			cpu_model_i.wr(4'h1, 8'h0A);
			begin
				@(posedge sys_clk) hw_event <= 4'h8;
				@(posedge sys_clk) hw_event <= 4'h0;
			end
		join
		cpu_model_i.rd(4'h0, q); chk(q, 8'h08);
		chk({4'h0, pending}, 8'h08);
		results();
	end
endmodule : timer_irq_pending_clear_tb_top

//--- timer_irq_pkg.sv
package timer_irq_pkg;

	// one bit for each interrupt source, d down to a
	typedef struct packed {
		logic src_d;
		logic src_c;
		logic src_b;
		logic src_a;
	} src_bits_t;

	// register port request from the cpu side
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : timer_irq_pkg

//--- tirq_checker.sv
`timescale 1ns/1ns
module tirq_checker import timer_irq_pkg::*; (input wire logic sys_clk, input wire logic reset,
	input wire reg_req_t reg_req, input wire logic [7:0] reg_rdata,
	input wire src_bits_t hw_event, input wire src_bits_t pending, input wire logic timer_irq);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_set_wins: assert property (1 |=> (pending & $past(hw_event)) == $past(hw_event))
		else $error("set lost");
	a_clr_ones: assert property (reg_req.rd && reg_req.addr == 4'h1 |=> reg_rdata == 8'hFF)
		else $error("clear read");
	a_no_drop: assert property (!(reg_req.wr && reg_req.addr == 4'h1) |=>
		($past(pending) & ~pending) == 4'h0) else $error("flag dropped");
	a_irq_idle: assert property (pending == 4'h0 |-> !timer_irq) else $error("stray irq");
	a_ctl_set: assert property (reg_req.wr && reg_req.addr == 4'h0 |=>
		($past(reg_req.wdata[3:0]) & ~pending) == 4'h0) else $error("set lost");
	a_clr_drops: assert property (reg_req.wr && reg_req.addr == 4'h1 && reg_req.wdata[0] &&
		!hw_event.src_a |=> !pending.src_a) else $error("clear ignored");
endmodule : tirq_checker
bind timer_irq_pending_clear tirq_checker tirq_checker_i (.*);
